/* verilog/fupc_pkg.sv */
// Package of constants for the flash unlock and protection controller.
// Assumes a byte-wide register port with 12-bit addresses and a 16-bit program address.
package fupc_pkg;
   // Register addresses.
   localparam logic [11:0] FUPC_CTRL_ADDR = 12'h0ff8;
   localparam logic [11:0] FUPC_PAGE_SEL_ADDR = 12'h0ff9;
   localparam logic [11:0] FUPC_STATUS_ADDR = 12'h0ffa;
   // Command and key codes written to the control register.
   localparam logic [7:0] FUPC_KEY1 = 8'h73;
   localparam logic [7:0] FUPC_KEY2 = 8'h8c;
   localparam logic [7:0] FUPC_CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] FUPC_CMD_SECT_PROT = 8'h5e;
   localparam logic [7:0] FUPC_CMD_MASS_ERASE = 8'h63;
   // Page select field layout and reset values of page select and sector protect.
   localparam int FUPC_INFO_EN_BIT = 7;
   localparam int FUPC_PAGE_MSB = 6;
   localparam int FUPC_PAGE_ADDR_LSB = 9;
   localparam logic [7:0] FUPC_PAGE_SEL_RST = 8'h00;
   localparam logic [7:0] FUPC_SECT_PROT_RST = 8'h00;
   // Sector geometry: eight sectors of at least one page (16 pages of 512 bytes).
   localparam int FUPC_NUM_SECTORS = 8;
   localparam int FUPC_SECT_SHIFT = 1;
   // Information area window in program space.
   localparam logic [15:0] FUPC_INFO_BASE = 16'hfe00;
   // Controller states.
   typedef enum logic [2:0] {
      FUPC_LOCKED,
      FUPC_PAGE_SEEN,
      FUPC_KEY1_SEEN,
      FUPC_KEY2_SEEN,
      FUPC_UNLOCKED,
      FUPC_PROT_ARMED
   } fupc_state_t;
endpackage : fupc_pkg

/* verilog/fupc_sync.sv */
// Two flip-flop synchroniser for a level input.
// Assumes the source is asynchronous to clk_i; the first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module fupc_sync (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic d_i,
   output var logic q_o
);
   logic meta_q;

   // Plain double register; reset value is low.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : fupc_sync
`default_nettype wire

/* verilog/fupc_ctrl.sv */
// Flash unlock and protection controller: lock sequence, page and sector protection.
// Assumes a one-cycle register port and a flash array that takes one-cycle command pulses.
//
// Behaviour
// [R1] Every reset leaves the controller locked; no program or erase possible.
// [R2] Software writes page, then 73H and 8CH back to back to control.
// [R3] Second page write must match the first, else relock; match activates page.
// [R4] Writing 95H while unlocked erases the active page if sector unprotected.
// [R5] Any unrecognised control value relocks the controller.
// [R6] Mass erase from user code is refused; only debug port may request it.
// [R7] Unlocked page accepts byte writes anywhere and stays unlocked afterwards.
// [R8] Any further control write while unlocked relocks the active page.
// [R9] Flash split into eight equal sectors, never smaller than a page.
// [R10] Protect bits block program and erase; user code cannot clear them.
// [R11] Sector protect register clears on reset.
// [R12] Shared address hits page select unless unlocked and 5EH written first.
// [R13] Pages are 512 bytes; erase covers addresses whose bits 15:9 match page.
// [R14] Page select bit 7 maps information area at FE00H to FFFFH.
// [R15] Software keeps unused upper page bits zero on small memories.
// [R16] Option bit at 0 disables all user program and erase; debug mass erase stays.
// [R17] Option bit at 1 allows program and erase subject to other protection.
// [R18] Byte writes outside the active page or to protected sectors are dropped.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fupc_ctrl (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output var logic [7:0] reg_rdata_o,
   input wire logic code_write_protect_option_i,
   input wire logic dbg_mass_erase_i,
   input wire logic [15:0] prog_addr_i,
   input wire logic [7:0] prog_data_i,
   input wire logic prog_wr_i,
   output var logic flash_prog_o,
   output var logic [15:0] flash_addr_o,
   output var logic [7:0] flash_data_o,
   output var logic flash_page_erase_o,
   output var logic [6:0] flash_erase_page_o,
   output var logic flash_mass_erase_o,
   output var logic info_sel_o,
   output var logic unlocked_o
);
   logic rst_meta_q;
   logic rst_b_q;
   logic wp_opt_s;
   logic dbg_me_s;
   logic dbg_me_q;
   fupc_pkg::fupc_state_t state_q;
   fupc_pkg::fupc_state_t state_d;
   logic [7:0] page_sel_q;
   logic [7:0] page_sel_d;
   logic [6:0] first_page_q;
   logic [6:0] first_page_d;
   logic [7:0] sect_prot_q;
   logic [7:0] sect_prot_d;

   // Reset is released through two flip-flops so downstream logic sees a clean edge.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_b_q <= rst_meta_q;
      end
   end

   // The option bit and debug request come from outside this clock domain.
   fupc_sync u_sync_wp (
      .clk_i(core_clk_i),
      .rst_b_i(rst_b_q),
      .d_i(code_write_protect_option_i),
      .q_o(wp_opt_s)
   );
   fupc_sync u_sync_dbg (
      .clk_i(core_clk_i),
      .rst_b_i(rst_b_q),
      .d_i(dbg_mass_erase_i),
      .q_o(dbg_me_s)
   );

   // Address decode of the register port.
   wire ctrl_wr = reg_wr_i && (reg_addr_i == fupc_pkg::FUPC_CTRL_ADDR);
   wire ps_wr = reg_wr_i && (reg_addr_i == fupc_pkg::FUPC_PAGE_SEL_ADDR);
   wire [6:0] wr_page = reg_wdata_i[fupc_pkg::FUPC_PAGE_MSB:0];
   wire [6:0] act_page = page_sel_q[fupc_pkg::FUPC_PAGE_MSB:0];
   wire is_unlocked = (state_q == fupc_pkg::FUPC_UNLOCKED);

   // Sector of a page: 16 pages into 8 sectors gives two pages per sector.
   wire [2:0] act_sect = 3'(act_page >> fupc_pkg::FUPC_SECT_SHIFT); // [R9]
   wire [6:0] prog_page = prog_addr_i[15:fupc_pkg::FUPC_PAGE_ADDR_LSB]; // [R13]
   wire [2:0] prog_sect = 3'(prog_page >> fupc_pkg::FUPC_SECT_SHIFT); // [R9]
   wire act_prot = sect_prot_q[act_sect]; // [R10]

   // Erase only from the unlocked state, for an unprotected sector, option allowing.
   wire erase_go = ctrl_wr && is_unlocked && wp_opt_s && !act_prot
      && (reg_wdata_i == fupc_pkg::FUPC_CMD_PAGE_ERASE); // [R4] [R16] [R17]
   // Bytes land only inside the active page and an unprotected sector.
   wire prog_go = prog_wr_i && is_unlocked && wp_opt_s && (prog_page == act_page)
      && !sect_prot_q[prog_sect]; // [R7] [R18] [R16]
   // A rising debug request gives mass erase; user writes of the code never do.
   wire mass_go = dbg_me_s && !dbg_me_q; // [R6] [R16]

   // Unlock sequencer and shared-address steering.
   always_comb begin
      state_d = state_q;
      page_sel_d = page_sel_q;
      first_page_d = first_page_q;
      sect_prot_d = sect_prot_q;
      unique case (state_q)
         fupc_pkg::FUPC_LOCKED, fupc_pkg::FUPC_PAGE_SEEN: begin
            if (ps_wr) begin
               page_sel_d = reg_wdata_i;
               first_page_d = wr_page;
               state_d = fupc_pkg::FUPC_PAGE_SEEN; // [R2]
            end else if (ctrl_wr) begin
               state_d = (state_q == fupc_pkg::FUPC_PAGE_SEEN
                  && reg_wdata_i == fupc_pkg::FUPC_KEY1)
                  ? fupc_pkg::FUPC_KEY1_SEEN : fupc_pkg::FUPC_LOCKED; // [R2] [R5]
            end
         end
         fupc_pkg::FUPC_KEY1_SEEN: begin
            // Keys must be consecutive writes; any other register write between them relocks.
            if (ctrl_wr && reg_wdata_i == fupc_pkg::FUPC_KEY2) begin
               state_d = fupc_pkg::FUPC_KEY2_SEEN; // [R2]
            end else if (reg_wr_i) begin
               state_d = fupc_pkg::FUPC_LOCKED; // [R2] [R5]
            end
         end
         fupc_pkg::FUPC_KEY2_SEEN: begin
            if (ps_wr) begin
               page_sel_d = reg_wdata_i;
               state_d = (wr_page == first_page_q)
                  ? fupc_pkg::FUPC_UNLOCKED : fupc_pkg::FUPC_LOCKED; // [R3]
            end else if (ctrl_wr) begin
               state_d = fupc_pkg::FUPC_LOCKED; // [R5]
            end
         end
         fupc_pkg::FUPC_UNLOCKED: begin
            if (ctrl_wr) begin
               // Any control write ends the unlock; 5EH arms protect-register access.
               state_d = (reg_wdata_i == fupc_pkg::FUPC_CMD_SECT_PROT)
                  ? fupc_pkg::FUPC_PROT_ARMED : fupc_pkg::FUPC_LOCKED; // [R8] [R5] [R4]
            end else if (ps_wr) begin
               page_sel_d = reg_wdata_i;
               state_d = fupc_pkg::FUPC_LOCKED; // [R3]
            end
         end
         fupc_pkg::FUPC_PROT_ARMED: begin
            if (ps_wr) begin
               // OR-in only: user code can set protection but never clear it.
               sect_prot_d = sect_prot_q | reg_wdata_i; // [R12] [R10]
               state_d = fupc_pkg::FUPC_LOCKED;
            end else if (ctrl_wr) begin
               state_d = fupc_pkg::FUPC_LOCKED; // [R5]
            end
         end
         default: begin
            state_d = fupc_pkg::FUPC_LOCKED;
         end
      endcase
   end

   // Read mux: page select, protect bits, and lock state at a status address.
   wire [7:0] status_v = {4'h0, wp_opt_s, act_prot, is_unlocked,
      state_q == fupc_pkg::FUPC_PROT_ARMED};
   wire [7:0] rdata_d = (reg_addr_i == fupc_pkg::FUPC_PAGE_SEL_ADDR) ? page_sel_q
      : (reg_addr_i == fupc_pkg::FUPC_CTRL_ADDR) ? sect_prot_q
      : (reg_addr_i == fupc_pkg::FUPC_STATUS_ADDR) ? status_v : 8'h00;

   // State, registers and flash strobes; reset locks everything and drops protection.
   always_ff @(posedge core_clk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         state_q <= fupc_pkg::FUPC_LOCKED; // [R1]
         page_sel_q <= fupc_pkg::FUPC_PAGE_SEL_RST;
         first_page_q <= 7'h00;
         sect_prot_q <= fupc_pkg::FUPC_SECT_PROT_RST; // [R11]
         dbg_me_q <= 1'b0;
         reg_rdata_o <= 8'h00;
         flash_prog_o <= 1'b0;
         flash_addr_o <= 16'h0000;
         flash_data_o <= 8'h00;
         flash_page_erase_o <= 1'b0;
         flash_erase_page_o <= 7'h00;
         flash_mass_erase_o <= 1'b0;
         info_sel_o <= 1'b0;
         unlocked_o <= 1'b0;
      end else begin
         state_q <= state_d;
         page_sel_q <= page_sel_d;
         first_page_q <= first_page_d;
         sect_prot_q <= sect_prot_d;
         dbg_me_q <= dbg_me_s;
         reg_rdata_o <= reg_rd_i ? rdata_d : 8'h00;
         flash_prog_o <= prog_go; // [R7] [R18]
         flash_addr_o <= prog_addr_i;
         flash_data_o <= prog_data_i;
         flash_page_erase_o <= erase_go; // [R4] [R13]
         flash_erase_page_o <= act_page; // [R13]
         flash_mass_erase_o <= mass_go; // [R6]
         info_sel_o <= page_sel_d[fupc_pkg::FUPC_INFO_EN_BIT]; // [R14]
         unlocked_o <= (state_d == fupc_pkg::FUPC_UNLOCKED);
      end
   end
endmodule : fupc_ctrl
`default_nettype wire

/* tb/fupc_ctrl_assertions.sv */
// Port checker for the flash unlock and protection controller.
// Assumes it is bound to fupc_ctrl and only watches its ports.
`timescale 1ns/10ps
`default_nettype none
module fupc_ctrl_assertions (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic prog_wr_i,
   input wire logic code_write_protect_option_i,
   input wire logic dbg_mass_erase_i,
   input wire logic flash_prog_o,
   input wire logic flash_page_erase_o,
   input wire logic flash_mass_erase_o,
   input wire logic unlocked_o
);
   // One clock domain, so clock and reset are given once for every property.
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Decoded register writes.
   wire ctl_wr = reg_wr_i && reg_addr_i == fupc_pkg::FUPC_CTRL_ADDR;
   wire ps_wr = reg_wr_i && reg_addr_i == fupc_pkg::FUPC_PAGE_SEL_ADDR;
   sequence keys_s;
      ctl_wr && reg_wdata_i == fupc_pkg::FUPC_KEY1 ##1
      ctl_wr && reg_wdata_i == fupc_pkg::FUPC_KEY2;
   endsequence
   // The internal reset lags the pin, so locking is demanded for three edges.
   reset_lock_a: assert property ($rose(rst_b_i) |-> !unlocked_o [*3])
      else $error("unlocked after reset");
   lock_prog_a: assert property (prog_wr_i && !unlocked_o |=> !flash_prog_o)
      else $error("program while locked");
   erase_cause_a: assert property (flash_page_erase_o |->
      $past(ctl_wr && unlocked_o && reg_wdata_i == fupc_pkg::FUPC_CMD_PAGE_ERASE))
      else $error("erase without command");
   ctrl_relock_a: assert property (ctl_wr && unlocked_o |=> !unlocked_o)
      else $error("no relock on control write");
   user_mass_a: assert property (!dbg_mass_erase_i [*6] |=> !flash_mass_erase_o)
      else $error("mass erase without debug");
   option_off_a: assert property (!code_write_protect_option_i [*4] ##0
      (prog_wr_i || ctl_wr) |=> !flash_prog_o && !flash_page_erase_o)
      else $error("write with option off");
   unlock_seq_a: assert property (!unlocked_o && !$past(ctl_wr) && ps_wr ##1 keys_s
      ##1 ps_wr && reg_wdata_i == $past(reg_wdata_i, 3) |=> unlocked_o)
      else $error("unlock failed");
   unlock_miss_a: assert property (ps_wr ##1 keys_s
      ##1 ps_wr && reg_wdata_i != $past(reg_wdata_i, 3) |=> !unlocked_o)
      else $error("unlock on mismatch");
endmodule : fupc_ctrl_assertions
bind fupc_ctrl fupc_ctrl_assertions fupc_ctrl_assertions_inst (.core_clk_i, .rst_b_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .prog_wr_i, .code_write_protect_option_i,
   .dbg_mass_erase_i, .flash_prog_o, .flash_page_erase_o, .flash_mass_erase_o, .unlocked_o);
`default_nettype wire

/* tb/fupc_flash_model.sv */
// Flash array model that tallies the operations it is given.
// Assumes one-cycle command pulses from the controller.
`timescale 1ns/10ps
`default_nettype none
module fupc_flash_model (
   input wire logic core_clk_i,
   input wire logic flash_prog_i,
   input wire logic flash_page_erase_i,
   input wire logic [6:0] flash_erase_page_i,
   input wire logic flash_mass_erase_i,
   input wire logic [15:0] flash_addr_i,
   input wire logic [7:0] flash_data_i
);
   int prog_cnt = 0;
   int erase_cnt = 0;
   int mass_cnt = 0;
   logic [6:0] last_page = 7'h00;
   logic [15:0] last_addr = 16'h0000;
   logic [7:0] last_data = 8'h00;
   // Counting, not storing, keeps the model small; a stray extra pulse still shows.
   always @(posedge core_clk_i) begin
      prog_cnt += int'(flash_prog_i);
      erase_cnt += int'(flash_page_erase_i);
      mass_cnt += int'(flash_mass_erase_i);
      if (flash_page_erase_i) begin
         last_page = flash_erase_page_i;
      end
      // Keep the last programmed byte so a dropped write cannot hide behind a count.
      if (flash_prog_i) begin
         last_addr = flash_addr_i;
         last_data = flash_data_i;
      end
   end
endmodule : fupc_flash_model
`default_nettype wire

/* tb/fupc_ctrl_tb.sv */
// Self-checking bench for the flash unlock and protection controller.
// Assumes the flash model sits on the controller's flash port.
`timescale 1ns/10ps
`default_nettype none
module fupc_ctrl_tb;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [11:0] reg_addr_i = 12'h000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic code_write_protect_option_i = 1'b1;
   logic dbg_mass_erase_i = 1'b0;
   logic [15:0] prog_addr_i = 16'h0000;
   logic [7:0] prog_data_i = 8'h00;
   logic [15:0] flash_addr_o;
   logic [7:0] reg_rdata_o, flash_data_o;
   logic [6:0] flash_erase_page_o;
   logic prog_wr_i = 1'b0;
   logic flash_prog_o, flash_page_erase_o, flash_mass_erase_o, info_sel_o, unlocked_o;
   int error_cnt = 0;
   int comparisons = 0;
   fupc_ctrl fupc_ctrl_inst (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .code_write_protect_option_i, .dbg_mass_erase_i, .prog_addr_i,
      .prog_data_i, .prog_wr_i, .flash_prog_o, .flash_addr_o, .flash_data_o,
      .flash_page_erase_o, .flash_erase_page_o, .flash_mass_erase_o, .info_sel_o, .unlocked_o);
   fupc_flash_model fupc_flash_model_inst (.core_clk_i, .flash_prog_i(flash_prog_o),
      .flash_page_erase_i(flash_page_erase_o), .flash_erase_page_i(flash_erase_page_o),
      .flash_mass_erase_i(flash_mass_erase_o), .flash_addr_i(flash_addr_o),
      .flash_data_i(flash_data_o));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Writes control when c is set, else page select; the strobe stays up for chaining.
   task automatic wr(input logic c, input logic [7:0] d);
      reg_addr_i <= c ? fupc_pkg::FUPC_CTRL_ADDR : fupc_pkg::FUPC_PAGE_SEL_ADDR;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
   endtask : wr
   task automatic idle();
      reg_wr_i <= 1'b0;
      prog_wr_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
   endtask : idle
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk("rdata", 16'(e), 16'(reg_rdata_o));
   endtask : rd
   // The data byte follows the address so a stale byte on the flash port shows.
   task automatic prog(input logic [15:0] a);
      prog_addr_i <= a;
      prog_data_i <= a[7:0] ^ 8'h3c;
      prog_wr_i <= 1'b1;
      @(posedge core_clk_i);
      idle();
   endtask : prog
   task automatic unl(input logic [7:0] p, input logic [7:0] q);
      wr(1'b0, p);
      wr(1'b1, fupc_pkg::FUPC_KEY1);
      wr(1'b1, fupc_pkg::FUPC_KEY2);
      wr(1'b0, q);
      idle();
   endtask : unl
   task automatic cnt(input int p, input int e, input int m);
      chk("prog", 16'(p), 16'(fupc_flash_model_inst.prog_cnt));
      chk("erase", 16'(e), 16'(fupc_flash_model_inst.erase_cnt));
      chk("mass", 16'(m), 16'(fupc_flash_model_inst.mass_cnt));
   endtask : cnt
   task automatic t_prog();
      unl(8'h02, 8'h02);
      chk("unlocked", 16'h0001, 16'(unlocked_o));
      rd(fupc_pkg::FUPC_STATUS_ADDR, 8'h0a);
      prog(16'h0400);
      prog(16'h05ff);
      prog(16'h0600);
      wr(1'b1, fupc_pkg::FUPC_CMD_PAGE_ERASE);
      idle();
      cnt(2, 1, 0);
      chk("page", 16'h0002, 16'(fupc_flash_model_inst.last_page));
      chk("addr", 16'h05ff, fupc_flash_model_inst.last_addr);
      chk("data", 16'h00c3, 16'(fupc_flash_model_inst.last_data));
      chk("unlocked", 16'h0000, 16'(unlocked_o));
   endtask : t_prog
   task automatic t_relock();
      unl(8'h02, 8'h03);
      chk("unlocked", 16'h0000, 16'(unlocked_o));
      unl(8'h04, 8'h04);
      wr(1'b1, fupc_pkg::FUPC_CMD_MASS_ERASE);
      idle();
      prog(16'h0800);
      cnt(2, 1, 0);
      wr(1'b0, 8'h80);
      idle();
      chk("info", 16'h0001, 16'(info_sel_o));
      rd(fupc_pkg::FUPC_PAGE_SEL_ADDR, 8'h80);
   endtask : t_relock
   task automatic t_protect();
      for (int i = 0; i < 2; i++) begin
         unl(8'h00, 8'h00);
         wr(1'b1, fupc_pkg::FUPC_CMD_SECT_PROT);
         wr(1'b0, i == 0 ? 8'h02 : 8'h00);
         idle();
         rd(fupc_pkg::FUPC_CTRL_ADDR, 8'h02);
      end
      unl(8'h02, 8'h02);
      prog(16'h0400);
      wr(1'b1, fupc_pkg::FUPC_CMD_PAGE_ERASE);
      unl(8'h04, 8'h04);
      wr(1'b1, fupc_pkg::FUPC_CMD_PAGE_ERASE);
      idle();
      cnt(2, 2, 0);
      rst_b_i <= 1'b0;
      idle();
      rst_b_i <= 1'b1;
      repeat (4) idle();
      rd(fupc_pkg::FUPC_CTRL_ADDR, 8'h00);
   endtask : t_protect
   task automatic t_option();
      code_write_protect_option_i <= 1'b0;
      repeat (4) idle();
      unl(8'h06, 8'h06);
      prog(16'h0c00);
      wr(1'b1, fupc_pkg::FUPC_CMD_PAGE_ERASE);
      dbg_mass_erase_i <= 1'b1;
      repeat (8) idle();
      cnt(2, 2, 1);
   endtask : t_option
   task automatic finish_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   initial begin
      forever #50 core_clk_i = ~core_clk_i;
   end
   // Main sequence; the shared reset release opens t_prog only, and each later scenario starts from the state left before it.
   initial begin
      repeat (20) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      repeat (4) idle();
      rd(fupc_pkg::FUPC_CTRL_ADDR, 8'h00);
      t_prog();
      t_relock();
      t_protect();
      t_option();
      finish_test();
   end
   initial begin
      repeat (3000) @(posedge core_clk_i);
      error_cnt++;
      finish_test();
   end
endmodule : fupc_ctrl_tb
`default_nettype wire
